/* File: rtl/nbc_pkg.sv */
// Contract
// RULE1: device select high disables the device and floats its I/O; standby when idle.
// RULE2: device select low enables the device for read and write bus cycles.
// RULE3: commands, addresses and data are valid at the write strobe rising edge.
// RULE4: each read strobe pulse gives the next page byte; column advances by one.
// RULE5: address latch high loads the I/O byte as an address byte.
// RULE6: command latch high loads the I/O byte as a command byte.
// RULE7: write-protect low refuses every program or erase start.
// RULE8: ready/busy is low during program, erase or array read, high when done.
// RULE9: ready/busy is open-drain; it only pulls low, never drives high.
// RULE10: eight shared I/O lines carry commands, addresses and data in time.
// RULE11: address cycles one and two carry the 12-bit column, low bits first.
// RULE12: address cycles three to five carry row bits 12..28; cycle five holds one bit.
// RULE13: unused bits of address cycles two and five are driven low.
// RULE14: address bit 18 selects the plane.
// RULE15: surplus address cycles beyond five are ignored by the device.
// RULE16: cache read is 31h, 00h then 31h, and last cache read is 3Fh.
// RULE17: program for copy back is 85h followed by 10h.
// RULE18: 30h moves the page to the page register; busy low until done.
// RULE19: only opcodes from the command set are ever issued.
// RULE20: page read is 00h, five address cycles, 30h; copy-back read confirms 35h.
// RULE21: program 80h..10h, cache program ends 15h, erase 60h, row, D0h.
// RULE22: while busy only read status 70h and reset FFh are accepted.
// RULE23: random data input 85h reloads the column within the page.
package nbc_pkg;

  localparam int NBC_CLK_MHZ    = 250;
  localparam int NBC_PHASE_NS   = 20;   // each strobe phase: setup, low, high
  localparam int NBC_PHASE_CYC  = (NBC_PHASE_NS * NBC_CLK_MHZ + 999) / 1000;
  localparam int NBC_WB_NS      = 100;  // strobe rise to busy valid
  localparam int NBC_WB_CYC     = (NBC_WB_NS * NBC_CLK_MHZ + 999) / 1000;

  localparam int NBC_COL_W      = 12;
  localparam int NBC_ROW_W      = 17;
  localparam int NBC_LEN_W      = 12;
  localparam int NBC_PLANE_POS  = 6;    // row bit holding address bit 18
  localparam logic [2:0] NBC_ADDR_FIRST_COL = 3'h0;
  localparam logic [2:0] NBC_ADDR_LAST_COL  = 3'h1;
  localparam logic [2:0] NBC_ADDR_FIRST_ROW = 3'h2;
  localparam logic [2:0] NBC_ADDR_LAST      = 3'h4;

  localparam logic [7:0] NBC_OP_READ      = 8'h00;
  localparam logic [7:0] NBC_OP_READ_GO   = 8'h30;
  localparam logic [7:0] NBC_OP_CB_GO     = 8'h35;
  localparam logic [7:0] NBC_OP_CACHE_RD  = 8'h31;
  localparam logic [7:0] NBC_OP_CACHE_END = 8'h3F;
  localparam logic [7:0] NBC_OP_STATUS    = 8'h70;
  localparam logic [7:0] NBC_OP_RESET     = 8'hFF;
  localparam logic [7:0] NBC_OP_PROG      = 8'h80;
  localparam logic [7:0] NBC_OP_PROG_GO   = 8'h10;
  localparam logic [7:0] NBC_OP_CACHE_GO  = 8'h15;
  localparam logic [7:0] NBC_OP_CB_PROG   = 8'h85;
  localparam logic [7:0] NBC_OP_ERASE     = 8'h60;
  localparam logic [7:0] NBC_OP_ERASE_GO  = 8'hD0;

  typedef enum logic [1:0] {
    NBC_K_CMD, NBC_K_ADDR, NBC_K_WR, NBC_K_RD
  } nbc_kind_t;

  typedef enum logic [3:0] {
    NBC_PAGE_READ, NBC_CB_READ, NBC_CACHE_SEQ, NBC_CACHE_RAND,
    NBC_CACHE_END, NBC_PROGRAM, NBC_CACHE_PROG, NBC_CB_PROG,
    NBC_RAND_DIN, NBC_ERASE, NBC_STATUS, NBC_RESET
  } nbc_op_t;

  // one user operation; len is data bytes minus one
  typedef struct packed {
    nbc_op_t                op;
    logic [NBC_COL_W-1:0]   col;
    logic [NBC_ROW_W-1:0]   row;
    logic [NBC_LEN_W-1:0]   len;
  } nbc_req_t;

  // bus sequence of one operation
  typedef struct packed {
    logic [7:0] cmd1;
    logic       addr;
    logic [2:0] firstAddr;
    logic [2:0] lastAddr;
    logic       wrData;
    logic       cmd2En;
    logic [7:0] cmd2;
    logic       waitRb;
    logic       rdData;
    logic       prog;
    logic       gated;
  } nbc_plan_t;

  function automatic nbc_plan_t nbc_plan(input nbc_op_t op);
    nbc_plan_t p;
    p = '{cmd1: NBC_OP_READ, addr: 1'b1, firstAddr: NBC_ADDR_FIRST_COL,
          lastAddr: NBC_ADDR_LAST, wrData: 1'b0, cmd2En: 1'b0,
          cmd2: NBC_OP_READ_GO, waitRb: 1'b1, rdData: 1'b0, prog: 1'b0,
          gated: 1'b1};
    case (op)
      NBC_PAGE_READ: begin
        p.cmd2En = 1'b1; // RULE20
        p.rdData = 1'b1;
      end
      NBC_CB_READ: begin
        p.cmd2En = 1'b1;
        p.cmd2   = NBC_OP_CB_GO; // RULE20
      end
      NBC_CACHE_SEQ, NBC_CACHE_END: begin
        p.cmd1   = (op == NBC_CACHE_SEQ) ? NBC_OP_CACHE_RD : NBC_OP_CACHE_END; // RULE16
        p.addr   = 1'b0;
        p.rdData = 1'b1;
      end
      NBC_CACHE_RAND: begin
        p.cmd2En = 1'b1;
        p.cmd2   = NBC_OP_CACHE_RD; // RULE16
        p.rdData = 1'b1;
      end
      NBC_PROGRAM, NBC_CACHE_PROG: begin
        p.cmd1   = NBC_OP_PROG; // RULE21
        p.wrData = 1'b1;
        p.cmd2En = 1'b1;
        p.cmd2   = (op == NBC_PROGRAM) ? NBC_OP_PROG_GO : NBC_OP_CACHE_GO;
        p.prog   = 1'b1;
      end
      NBC_CB_PROG: begin
        p.cmd1   = NBC_OP_CB_PROG; // RULE17
        p.cmd2En = 1'b1;
        p.cmd2   = NBC_OP_PROG_GO;
        p.prog   = 1'b1;
      end
      NBC_RAND_DIN: begin
        p.cmd1     = NBC_OP_CB_PROG; // RULE23
        p.lastAddr = NBC_ADDR_LAST_COL;
        p.wrData   = 1'b1;
        p.waitRb   = 1'b0;
        p.prog     = 1'b1;
      end
      NBC_ERASE: begin
        p.cmd1      = NBC_OP_ERASE; // RULE21
        p.firstAddr = NBC_ADDR_FIRST_ROW;
        p.cmd2En    = 1'b1;
        p.cmd2      = NBC_OP_ERASE_GO;
        p.prog      = 1'b1;
      end
      NBC_STATUS: begin
        p.cmd1   = NBC_OP_STATUS; // RULE22
        p.addr   = 1'b0;
        p.waitRb = 1'b0;
        p.rdData = 1'b1;
        p.gated  = 1'b0;
      end
      default: begin
        p.cmd1  = NBC_OP_RESET; // RULE22
        p.addr  = 1'b0;
        p.gated = 1'b0;
      end
    endcase
    return p;
  endfunction : nbc_plan

endpackage : nbc_pkg

/* File: rtl/nbc_bus_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
// one byte cycle on the shared bus: setup, strobe low, strobe high
module nbc_bus_cycle
  import nbc_pkg::*;
#(
  parameter int PHASE_CYC = NBC_PHASE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       req,
  input  wire nbc_kind_t  kind,
  input  wire logic [7:0] wrByte,
  output logic            accept,
  output logic            done,
  output logic [7:0]      rdByte,
  output logic            cle,
  output logic            ale,
  output logic            weN,
  output logic            reN,
  output logic [7:0]      ioOut,
  output logic            ioOeN,
  input  wire logic [7:0] ioIn
);

  if (PHASE_CYC < 1) begin : g_chk
    $error("PHASE_CYC must be at least 1");
  end

  typedef enum logic [3:0] {
    P_IDLE  = 4'b0001,
    P_SETUP = 4'b0010,
    P_LOW   = 4'b0100,
    P_HIGH  = 4'b1000
  } nbc_phase_t;

  nbc_phase_t       phase_r;
  nbc_kind_t        kind_r;
  logic [15:0]      div_r;
  logic             tick;

  assign accept = (phase_r == P_IDLE) && req;
  assign tick   = (div_r == 16'(PHASE_CYC - 1));
  assign done   = (phase_r == P_HIGH) && tick;

  // phase divider, restarts with each cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
    end else if (phase_r == P_IDLE || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // phase sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= P_IDLE;
    end else begin
      case (phase_r)
        P_IDLE:  if (req) phase_r <= P_SETUP;
        P_SETUP: if (tick) phase_r <= P_LOW;
        P_LOW:   if (tick) phase_r <= P_HIGH;
        P_HIGH:  if (tick) phase_r <= P_IDLE;
        default: phase_r <= P_IDLE;
      endcase
    end
  end

  // byte and kind held for the whole cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_r <= NBC_K_CMD;
      ioOut  <= 8'h00;
    end else if (accept) begin
      kind_r <= kind;
      ioOut  <= wrByte; // RULE10
    end
  end

  // sample late in the low phase, after the access time has passed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdByte <= 8'h00;
    end else if (phase_r == P_LOW && tick && kind_r == NBC_K_RD) begin
      rdByte <= ioIn; // RULE4
    end
  end

  // latches stay up through the rising edge and the hold phase
  always_comb begin
    cle   = (phase_r != P_IDLE) && (kind_r == NBC_K_CMD);  // RULE6
    ale   = (phase_r != P_IDLE) && (kind_r == NBC_K_ADDR); // RULE5
    weN   = !((phase_r == P_LOW) && (kind_r != NBC_K_RD)); // RULE3
    reN   = !((phase_r == P_LOW) && (kind_r == NBC_K_RD));
    ioOeN = (phase_r == P_IDLE) || (kind_r == NBC_K_RD);   // RULE10
  end

endmodule : nbc_bus_cycle
`default_nettype wire

/* File: rtl/nbc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host side sequencer: turns whole operations into bus cycles
module nbc_host
  import nbc_pkg::*;
#(
  parameter int PHASE_CYC = NBC_PHASE_CYC,
  parameter int WB_CYC    = NBC_WB_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       reqValid,
  output logic            reqReady,
  input  wire nbc_req_t   req,
  input  wire logic       writeProtect,
  output logic            opDone,
  output logic            opRefused,
  input  wire logic       wrValid,
  input  wire logic [7:0] wrData,
  output logic            wrReady,
  output logic            rdValid,
  output logic [7:0]      rdData,
  output logic            ceN,
  output logic            cle,
  output logic            ale,
  output logic            weN,
  output logic            reN,
  output logic            wpN,
  input  wire logic [7:0] ioIn,
  output logic [7:0]      ioOut,
  output logic            ioOeN,
  input  wire logic       rbIn
);

  if (WB_CYC < 1 || WB_CYC > 255) begin : g_chk
    $error("WB_CYC must be 1..255");
  end

  typedef enum logic [9:0] {
    S_IDLE = 10'b0000000001,
    S_PRE  = 10'b0000000010,
    S_CMD1 = 10'b0000000100,
    S_ADDR = 10'b0000001000,
    S_WR   = 10'b0000010000,
    S_CMD2 = 10'b0000100000,
    S_WB   = 10'b0001000000,
    S_RB   = 10'b0010000000,
    S_RD   = 10'b0100000000,
    S_DONE = 10'b1000000000
  } nbc_state_t;

  nbc_state_t             state_r;
  nbc_state_t             stateNxt;
  nbc_state_t             postAddr;
  nbc_state_t             postWr;
  nbc_state_t             postCmd2;
  nbc_req_t               req_r;
  nbc_plan_t              plan;
  nbc_plan_t              inPlan;
  logic                   refuse;
  logic [2:0]             idx_r;
  logic [NBC_LEN_W-1:0]   cnt_r;
  logic [7:0]             wbCnt_r;
  logic                   refused_r;
  logic                   wpN_r;
  logic                   rdValid_r;
  logic [7:0]             rdData_r;
  logic                   engReq;
  nbc_kind_t              engKind;
  logic [7:0]             engByte;
  logic                   engAccept;
  logic                   engDone;
  logic [7:0]             engRdByte;
  logic                   engIoOeN;

  assign plan   = nbc_plan(req_r.op);
  assign inPlan = nbc_plan(req.op);
  // program and erase are never started under write protect
  assign refuse = writeProtect && inPlan.prog; // RULE7

  // address byte layout; spare bits of cycles two and five held low
  function automatic logic [7:0] addrByte(input logic [2:0] i,
                                          input nbc_req_t r);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      3'h0: b = r.col[7:0];                 // RULE11
      3'h1: b = {4'h0, r.col[11:8]};        // RULE11 RULE13
      3'h2: b = r.row[7:0];                 // RULE12 RULE14
      3'h3: b = r.row[15:8];                // RULE12
      default: b = {7'h00, r.row[16]};      // RULE12 RULE13
    endcase
    return b;
  endfunction : addrByte

  // stage that follows each optional part of the sequence
  always_comb begin
    postCmd2 = plan.waitRb ? S_WB : (plan.rdData ? S_RD : S_DONE);
    postWr   = plan.cmd2En ? S_CMD2 : postCmd2;
    postAddr = plan.wrData ? S_WR : postWr;
  end

  // operation sequencing
  always_comb begin
    stateNxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (reqValid) stateNxt = refuse ? S_DONE : S_PRE;
      end
      S_PRE: begin
        // only status and reset go out while the device is busy
        if (rbIn || !plan.gated) stateNxt = S_CMD1; // RULE22
      end
      S_CMD1: begin
        if (engDone) stateNxt = plan.addr ? S_ADDR : postAddr;
      end
      S_ADDR: begin
        // exactly the cycles needed; no surplus address bytes
        if (engDone && idx_r == plan.lastAddr) stateNxt = postAddr; // RULE15
      end
      S_WR: begin
        if (engDone && cnt_r == '0) stateNxt = postWr;
      end
      S_CMD2: begin
        if (engDone) stateNxt = postCmd2;
      end
      S_WB: begin
        if (wbCnt_r == 8'h00) stateNxt = S_RB;
      end
      S_RB: begin
        // wait for the array transfer, program, erase or reset to finish
        if (rbIn) stateNxt = plan.rdData ? S_RD : S_DONE; // RULE8 RULE18
      end
      S_RD: begin
        if (engDone && cnt_r == '0) stateNxt = S_DONE;
      end
      S_DONE: begin
        stateNxt = S_IDLE;
      end
      default: begin
        stateNxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= stateNxt;
    end
  end

  // request capture and refusal flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r     <= '0;
      refused_r <= 1'b0;
    end else if (state_r == S_IDLE && reqValid) begin
      req_r     <= req;
      refused_r <= refuse; // RULE7
    end
  end

  // write protect pin follows the last accepted operation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wpN_r <= 1'b0;
    end else if (writeProtect) begin
      wpN_r <= 1'b0; // RULE7
    end else if (state_r == S_IDLE && reqValid) begin
      wpN_r <= inPlan.prog;
    end
  end

  // address byte index
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_r <= 3'h0;
    end else if (state_r == S_IDLE && reqValid) begin
      idx_r <= inPlan.firstAddr;
    end else if (state_r == S_ADDR && engDone) begin
      idx_r <= idx_r + 3'h1;
    end
  end

  // data byte count; each read pulse is one column step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_r == S_IDLE && reqValid) begin
      cnt_r <= req.len;
    end else if ((state_r == S_WR || state_r == S_RD) && engDone) begin
      cnt_r <= cnt_r - NBC_LEN_W'(1); // RULE4
    end
  end

  // busy is not valid right after the confirm edge, so wait first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbCnt_r <= 8'h00;
    end else if (stateNxt == S_WB && state_r != S_WB) begin
      wbCnt_r <= 8'(WB_CYC - 1); // RULE8
    end else if (state_r == S_WB && wbCnt_r != 8'h00) begin
      wbCnt_r <= wbCnt_r - 8'h01;
    end
  end

  // read data out, one pulse per byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_r <= 1'b0;
      rdData_r  <= 8'h00;
    end else begin
      rdValid_r <= (state_r == S_RD) && engDone;
      if (state_r == S_RD && engDone) begin
        rdData_r <= engRdByte; // RULE4
      end
    end
  end

  // what the byte engine sends now; only table opcodes are used
  always_comb begin
    engReq  = 1'b0;
    engKind = NBC_K_CMD;
    engByte = plan.cmd1; // RULE19
    case (state_r)
      S_CMD1: begin
        engReq = 1'b1;
      end
      S_ADDR: begin
        engReq  = 1'b1;
        engKind = NBC_K_ADDR;
        engByte = addrByte(idx_r, req_r);
      end
      S_WR: begin
        engReq  = wrValid;
        engKind = NBC_K_WR;
        engByte = wrData;
      end
      S_CMD2: begin
        engReq  = 1'b1;
        engByte = plan.cmd2;
      end
      S_RD: begin
        engReq  = 1'b1;
        engKind = NBC_K_RD;
      end
      default: begin
        engReq = 1'b0;
      end
    endcase
  end

  nbc_bus_cycle #(
    .PHASE_CYC (PHASE_CYC)
  ) u_cycle (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .req      (engReq),
    .kind     (engKind),
    .wrByte   (engByte),
    .accept   (engAccept),
    .done     (engDone),
    .rdByte   (engRdByte),
    .cle      (cle),
    .ale      (ale),
    .weN      (weN),
    .reN      (reN),
    .ioOut    (ioOut),
    .ioOeN    (engIoOeN),
    .ioIn     (ioIn)
  );

  // device deselected between operations so it floats and idles
  always_comb begin
    ceN = (state_r == S_IDLE) || (state_r == S_DONE); // RULE1 RULE2
  end

  // handshakes and registered outputs
  assign reqReady  = (state_r == S_IDLE);
  assign wrReady   = (state_r == S_WR) && engAccept;
  assign opDone    = (state_r == S_DONE);
  assign opRefused = refused_r;
  assign wpN       = wpN_r;
  assign rdValid   = rdValid_r;
  assign rdData    = rdData_r;
  // ready/busy is only sensed; the line relies on its pull-up
  assign ioOeN     = engIoOeN | ceN; // RULE9 RULE10

endmodule : nbc_host
`default_nettype wire

/* File: verification/nbc_host_props.sv */
`timescale 1ns/1ps
`default_nettype none
// protocol watch on the host side pins of the flash sequencer
module nbc_host_props
  import nbc_pkg::*;
#(
  parameter int PHASE_CYC = NBC_PHASE_CYC,
  parameter int WB_CYC    = NBC_WB_CYC
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       reqReady,
  input wire logic       writeProtect,
  input wire logic       opDone,
  input wire logic       opRefused,
  input wire logic       ceN,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       weN,
  input wire logic       reN,
  input wire logic       wpN,
  input wire logic [7:0] ioOut,
  input wire logic       ioOeN,
  input wire logic       rbIn
);
  logic [7:0] lowCnt_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // strobe low length; cleared whenever both strobes are high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lowCnt_r <= 8'h00;
    else lowCnt_r <= (weN && reN) ? 8'h00 : lowCnt_r + 8'h01;
  end

  idle_deselect_a: assert property (reqReady |-> ceN && ioOeN)
    else $error("bus not released while idle");
  io_select_a: assert property (!ioOeN || cle || ale |-> !ceN)
    else $error("bus driven while deselected");
  latch_excl_a: assert property (!(cle && ale))
    else $error("both latch strobes high");
  latch_hold_a: assert property (!weN ##1 weN |-> $stable(ioOut) && $stable(cle)
                                  && $stable(ale) && !ioOeN)
    else $error("byte or latch moved at write strobe rise");
  strobe_width_a: assert property ($rose(weN) || $rose(reN) |->
                                    lowCnt_r == 8'(PHASE_CYC))
    else $error("strobe low time wrong");
  read_release_a: assert property (!reN |-> ioOeN && !ceN && !cle && !ale)
    else $error("host drives bus during read strobe");
  wp_force_a: assert property (writeProtect |=> !wpN)
    else $error("write protect not forced low");
  refuse_quiet_a: assert property (opDone && opRefused |-> ceN && $past(ceN) && weN)
    else $error("refused operation touched the bus");
  busy_gate_a: assert property ($rose(cle) && ioOut != 8'h70 && ioOut != 8'hFF
                                 |-> rbIn)
    else $error("command issued while device busy");
  busy_wait_a: assert property ($rose(weN) && cle && ioOut == 8'h30 |=> reN [*3])
    else $error("read strobe before busy window");
endmodule : nbc_host_props
`default_nettype wire

/* File: verification/nbc_nand_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural flash device on the far side of the host bus
module nbc_nand_model
  import nbc_pkg::*;
#(
  parameter int BUSY_NS = 120
) (
  input  wire logic       core_clk,
  input  wire logic       ceN,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       weN,
  input  wire logic       reN,
  input  wire logic       wpN,
  input  wire logic [7:0] hostIo,
  input  wire logic       ioOeN,
  output logic      [7:0] ioWire,
  output logic            rbIn
);
  logic [7:0]  devData = 8'hA5;
  logic        devOe   = 1'b0;
  logic        rbLow   = 1'b0;
  logic        stat    = 1'b0;
  logic [7:0]  ab [5];
  logic [11:0] col;
  logic [16:0] row;
  logic        plane;
  int          nAddr   = 5;
  int          nViol   = 0;
  time         busyEnd = 0;
  logic [9:0]  log [$];

  // released bus shows the inverse of the last byte, never a stale copy
  assign ioWire = !ioOeN ? hostIo : devOe ? devData : ~devData;
  assign rbIn   = rbLow ? 1'b0 : 1'b1;
  assign plane  = row[NBC_PLANE_POS];

  // busy timer kept on the bench clock for simplicity
  always @(posedge core_clk) rbLow <= ($time < busyEnd);

  // write strobe latches only while selected
  always @(posedge weN) if (!ceN) begin
    if (cle) begin
      log.push_back({2'h0, hostIo});
      if (rbLow && hostIo != 8'h70 && hostIo != 8'hFF) nViol++;
      if (!(hostIo inside {8'h00, 8'h30, 8'h35, 8'h31, 8'h3F, 8'h70, 8'hFF,
                           8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0})) nViol++;
      stat = (hostIo == 8'h70);
      if (hostIo inside {8'h00, 8'h80, 8'h85, 8'h60}) nAddr = (hostIo == 8'h60) ? 2 : 0;
      if (hostIo inside {8'h31, 8'h3F}) col = '0;
      if (hostIo inside {8'h30, 8'h35, 8'h31, 8'h3F, 8'hFF} ||
          (wpN && hostIo inside {8'h10, 8'h15, 8'hD0}))
        busyEnd = $time + BUSY_NS;
    end else if (ale) begin
      log.push_back({2'h1, hostIo});
      if (nAddr < 5) begin
        if ((nAddr == 1 && hostIo[7:4] != 4'h0) || (nAddr == 4 && hostIo[7:1] != 7'h00))
          nViol++;
        ab[nAddr] = hostIo;
        col = {ab[1][3:0], ab[0]};
        row = {ab[4][0], ab[3], ab[2]};
        nAddr++;
      end
    end else log.push_back({2'h2, hostIo});
  end

  // byte out while the read strobe is low
  always @(negedge reN) if (!ceN) begin
    devData = stat ? {wpN, !rbLow, 6'h00} : (row[7:0] ^ col[7:0] ^ 8'h5A);
    devOe   = 1'b1;
  end

  // column steps on strobe release; deselect floats the bus
  always @(posedge reN or posedge ceN) begin
    if (devOe && !stat) col++;
    devOe = 1'b0;
  end
endmodule : nbc_nand_model
`default_nettype wire

/* File: verification/tb_nbc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// bench for the flash host sequencer against a behavioural device
module tb_nbc_host
  import nbc_pkg::*;
;
  localparam int P = 2;
  localparam int WB = 3;
  // per operation: first command, second command (bit 8 = present), address span
  localparam logic [7:0] C1 [12] = '{8'h00, 8'h00, 8'h31, 8'h00, 8'h3F, 8'h80, 8'h80,
                                     8'h85, 8'h85, 8'h60, 8'h70, 8'hFF};
  localparam logic [8:0] C2 [12] = '{9'h130, 9'h135, 9'h000, 9'h131, 9'h000, 9'h110,
                                     9'h115, 9'h110, 9'h000, 9'h1D0, 9'h000, 9'h000};
  localparam int A0 [12] = '{0, 0, 5, 0, 5, 0, 0, 0, 0, 2, 5, 5};
  localparam int A1 [12] = '{4, 4, 4, 4, 4, 4, 4, 4, 1, 4, 4, 4};
  localparam logic [11:0] WRM = 12'h160;
  localparam logic [11:0] RDM = 12'h41D;
  localparam logic [11:0] PG  = 12'h3E0;

  logic       core_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, writeProtect, wrValid;
  logic       reqReady, opDone, opRefused, wrReady, rdValid, ceN, cle, ale, weN, reN;
  logic       wpN, ioOeN, rbIn;
  logic [7:0] wrData, rdData, ioIn, ioOut;
  nbc_req_t   req;
  logic [9:0] expQ [$];
  int         nMismatch = 0, nCompared = 0, seed = 71;

  always #2 core_clk = ~core_clk;

  nbc_host #(.PHASE_CYC(P), .WB_CYC(WB)) nbc_host_inst (
    .core_clk(core_clk), .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .writeProtect(writeProtect), .opDone(opDone), .opRefused(opRefused),
    .wrValid(wrValid), .wrData(wrData), .wrReady(wrReady), .rdValid(rdValid),
    .rdData(rdData), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN),
    .wpN(wpN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .rbIn(rbIn));

  nbc_nand_model nbc_nand_model_inst (
    .core_clk(core_clk), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN), .reN(reN),
    .wpN(wpN), .hostIo(ioOut), .ioOeN(ioOeN), .ioWire(ioIn), .rbIn(rbIn));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic giveVerdict();
    if (nMismatch == 0 && nCompared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : giveVerdict

  // address byte k of an operation, unused positions low
  function automatic logic [7:0] abyte(input nbc_req_t r, input int k);
    case (k)
      0: return r.col[7:0];
      1: return {4'h0, r.col[11:8]};
      2: return r.row[7:0];
      3: return r.row[15:8];
      default: return {7'h00, r.row[16]};
    endcase
  endfunction : abyte

  // one whole operation: drive, collect, compare against the device log
  task automatic runOp(input nbc_req_t r, input logic wp, input logic [7:0] base);
    int         o, k, w, n;
    logic       fin, tk, rf, gone;
    logic [7:0] got [$];
    o    = int'(r.op);
    gone = wp && PG[o];
    expQ.delete();
    nbc_nand_model_inst.log.delete();
    if (!gone) begin
      expQ.push_back({2'h0, C1[o]});
      for (k = A0[o]; k <= A1[o]; k++) expQ.push_back({2'h1, abyte(r, k)});
      for (k = 0; WRM[o] && k <= r.len; k++) expQ.push_back({2'h2, base + 8'(k)});
      if (C2[o][8]) expQ.push_back({2'h0, C2[o][7:0]});
    end
    req = r;
    writeProtect = wp;
    reqValid = 1'b1;
    wrData = base;
    wrValid = WRM[o];
    w = 0; fin = 0; tk = 0; rf = 0;
    for (n = 0; n < 3000 && !fin; n++) begin
      @(posedge core_clk);
      if (reqValid && reqReady) tk = 1'b1;
      if (wrValid && wrReady) w++;
      if (rdValid) got.push_back(rdData);
      if (opDone) begin
        fin = 1'b1;
        rf = opRefused;
      end
      #1;
      // leave the last step alone so the next call drives it once
      if (!fin) begin
        if (tk) reqValid = 1'b0;
        wrData = base + 8'(w);
        wrValid = WRM[o] && w <= r.len;
      end
    end
    if (!fin) begin
      nMismatch++;
      giveVerdict();
    end
    check("refused", rf, gone);
    check("deselect", ceN, 1'b1);
    check("byte count", nbc_nand_model_inst.log.size(), expQ.size());
    foreach (expQ[i]) check("bus byte", nbc_nand_model_inst.log[i], expQ[i]);
    check("device view", nbc_nand_model_inst.nViol, 16'h0000);
    if (!gone && A0[o] < 5 && A1[o] == 4)
      check("plane", nbc_nand_model_inst.plane, r.row[NBC_PLANE_POS]);
    check("reads", got.size(), (RDM[o] && !gone) ? r.len + 1 : 0);
    foreach (got[i])
      if (o == 0) check("page byte", got[i], r.row[7:0] ^ (r.col[7:0] + 8'(i)) ^ 8'h5A);
      else if (o == 10) check("status", got[i], 8'h40);
  endtask : runOp

  // corner pass, random pass, random pass with write protect
  initial begin
    nbc_req_t r;
    int       p, o;
    req = '0;
    writeProtect = 1'b0;
    wrValid = 1'b0;
    wrData = 8'h00;
    repeat (4) @(posedge core_clk);
    #1 rst_n = 1'b1;
    for (p = 0; p < 3; p++)
      for (o = 0; o < 12; o++) begin
        r.op  = nbc_op_t'(o);
        r.col = (p == 0) ? 12'hFFF : 12'($random(seed));
        r.row = (p == 0) ? 17'h1FFFF : 17'($random(seed));
        r.len = (p == 0) ? 12'h000 : 12'($random(seed) & 3);
        runOp(r, p == 2 && PG[o], 8'($random(seed)));
      end
    req.op = NBC_PAGE_READ;
    reqValid = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b0;
    reqValid = 1'b0;
    #1 check("reset select", ceN, 1'b1);
    check("reset bus", ioOeN, 1'b1);
    @(posedge core_clk) #1 rst_n = 1'b1;
    runOp(req, 1'b0, 8'h3C);
    giveVerdict();
  end
endmodule : tb_nbc_host

bind nbc_host nbc_host_props #(.PHASE_CYC(PHASE_CYC), .WB_CYC(WB_CYC)) nbc_host_props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .reqReady(reqReady), .writeProtect(writeProtect),
  .opDone(opDone), .opRefused(opRefused), .ceN(ceN), .cle(cle), .ale(ale), .weN(weN),
  .reN(reN), .wpN(wpN), .ioOut(ioOut), .ioOeN(ioOeN), .rbIn(rbIn));
`default_nettype wire
